// [verilog/sbst_tap.sv]
// Boundary-scan test port of a burst memory: sampling, scan registers and serial output
`timescale 1ns/10ps
`include "sbst_consts.svh"

module sbst_tap #(
    parameter int                            BSR_W    = `SBST_BSR_W,
    parameter logic [2:0]                    ID_REV   = 3'h1,      // Arbitrary value
    parameter logic [16:0]                   ID_DEVICE = 17'h0a5c3, // Arbitrary value
    parameter logic [10:0]                   ID_VENDOR = 11'h2b1    // Arbitrary value
) (
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic             tck,
    input  wire logic             tms,
    input  wire logic             tdi,
    output logic                  tdo,
    output logic                  tdo_oe,
    input  wire logic [BSR_W-1:0] pin_sample,
    output logic [BSR_W-1:0]      preload_out,
    output logic                  test_owns_pins,
    output logic                  q_bus_float
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    localparam logic [`SBST_ID_W-1:0] ID_CODE = {ID_REV, ID_DEVICE, ID_VENDOR, `SBST_ID_PRESENT};

    sbst_if tap ();

    logic [2:0]                 tck_sync;
    logic [1:0]                 tms_sync;
    logic [1:0]                 tdi_sync;
    logic [BSR_W-1:0]           pin_meta;
    logic [BSR_W-1:0]           pin_sync;
    logic                       tck_fall;
    logic                       tdi_s;
    sbst_pkg::sbst_instr_t      ir_shift;
    sbst_pkg::sbst_instr_t      ir_active;
    logic                       bypass_bit;
    logic [`SBST_ID_W-1:0]      id_shift;
    logic [BSR_W-1:0]           bsr_shift;
    sbst_pkg::sbst_sel_e        dr_sel;
    logic                       next_tdo;
    logic                       next_owns;
    logic                       next_float;
    logic                       in_reset;
    logic                       in_cap_ir;
    logic                       in_shf_ir;
    logic                       in_cap_dr;
    logic                       in_shf_dr;
    logic                       update_ir;
    logic                       update_dr;
    logic                       oe_cell;

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    // Map an instruction onto the data register it connects
    function automatic sbst_pkg::sbst_sel_e sel_of(input sbst_pkg::sbst_instr_t ins);
        sbst_pkg::sbst_sel_e s;
        s = sbst_pkg::SEL_BYPASS;
        unique case (ins)
            `SBST_INS_EXTEST: s = sbst_pkg::SEL_BOUNDARY;
            `SBST_INS_IDCODE: s = sbst_pkg::SEL_IDENT;
            `SBST_INS_SAMPZ:  s = sbst_pkg::SEL_BOUNDARY;
            `SBST_INS_SAMPLE: s = sbst_pkg::SEL_BOUNDARY;
            `SBST_INS_BYPASS: s = sbst_pkg::SEL_BYPASS;
            // Reserved codes are not expected, bypass is the harmless answer
            default:          s = sbst_pkg::SEL_BYPASS;
        endcase
        return s;
    endfunction

    // True in the two states that move data through the chain
    function automatic logic is_shift(input sbst_pkg::sbst_state_e st);
        return (st == sbst_pkg::ST_SHF_DR) || (st == sbst_pkg::ST_SHF_IR);
    endfunction

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    // Test clock gets a third stage for edge finding; first stage is read by the second only
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tck_sync <= 3'h0;
        end else begin
            tck_sync <= {tck_sync[1:0], tck};
        end
    end

    // Mode select idles high, as its pull-up would leave it; a stray walk only reaches reset
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tms_sync <= {2{`SBST_PULL_LEVEL}};
        end else begin
            tms_sync <= {tms_sync[0], tms};
        end
    end

    // Data in idles high too, so an open pin shifts in ones
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tdi_sync <= {2{`SBST_PULL_LEVEL}};
        end else begin
            tdi_sync <= {tdi_sync[0], tdi};
        end
    end

    // Memory pins arrive on a faster clock; a pin moving near capture may read either way
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= pin_sample;
            pin_sync <= pin_meta;
        end
    end

    // Edges of the test clock; data and mode select share its delay, so setup is kept
    assign tap.tck_rise = tck_sync[1] & ~tck_sync[2];
    assign tck_fall     = ~tck_sync[1] & tck_sync[2];
    assign tap.tms      = tms_sync[1];
    assign tdi_s        = tdi_sync[1];

    // ----------------------------------------------------------------
    // State controller
    // ----------------------------------------------------------------
    sbst_tap_fsm u_fsm (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .tap      (tap.fsm)
    );

    // Only one data register is chosen, by the active instruction
    assign dr_sel = sel_of(ir_active);

    // ----------------------------------------------------------------
    // State decodes
    // ----------------------------------------------------------------
    // Levels shared by several registers; the reset level acts at once, the others wait for a test clock edge
    assign in_reset  = (tap.state == sbst_pkg::ST_RESET);
    assign in_cap_ir = (tap.state == sbst_pkg::ST_CAP_IR);
    assign in_shf_ir = (tap.state == sbst_pkg::ST_SHF_IR);
    assign in_cap_dr = (tap.state == sbst_pkg::ST_CAP_DR);
    assign in_shf_dr = (tap.state == sbst_pkg::ST_SHF_DR);

    // ----------------------------------------------------------------
    // Update strobes
    // ----------------------------------------------------------------
    // Updates wait for the fall inside the state, half a period after entering it and one and a half after the last shift
    assign update_ir = tck_fall && (tap.state == sbst_pkg::ST_UPD_IR);
    assign update_dr = tck_fall && (tap.state == sbst_pkg::ST_UPD_DR);

    // ----------------------------------------------------------------
    // Instruction register
    // ----------------------------------------------------------------
    // Shift stage: capture pattern, then data in at the top bit
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ir_shift <= `SBST_INS_IDCODE;
        end else if (tap.tck_rise) begin
            if (in_cap_ir) begin
                ir_shift <= `SBST_IR_CAPTURE;
            end else if (in_shf_ir) begin
                ir_shift <= {tdi_s, ir_shift[`SBST_IR_W-1:1]};
            end
        end
    end

    // Active instruction changes in Update-IR on the falling edge, and returns to IDCODE in the reset state
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ir_active <= `SBST_INS_IDCODE;
        end else if (in_reset) begin
            ir_active <= `SBST_INS_IDCODE;
        end else if (update_ir) begin
            ir_active <= ir_shift;
        end
    end

    // ----------------------------------------------------------------
    // Bypass and identification registers
    // ----------------------------------------------------------------
    // Single stage, cleared on capture so the chain shows a known zero
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bypass_bit <= `SBST_BYP_CAPTURE;
        end else if (tap.tck_rise && dr_sel == sbst_pkg::SEL_BYPASS) begin
            if (in_cap_dr) begin
                bypass_bit <= `SBST_BYP_CAPTURE;
            end else if (in_shf_dr) begin
                bypass_bit <= tdi_s;
            end
        end
    end

    // Hardwired code loaded at capture and walked out LSB first
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            id_shift <= '0;
        end else if (tap.tck_rise && dr_sel == sbst_pkg::SEL_IDENT) begin
            if (in_cap_dr) begin
                id_shift <= ID_CODE;
            end else if (in_shf_dr) begin
                id_shift <= {tdi_s, id_shift[`SBST_ID_W-1:1]};
            end
        end
    end

    // ----------------------------------------------------------------
    // Boundary register
    // ----------------------------------------------------------------
    // Capture takes a pin snapshot; memory traffic is never touched by it
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bsr_shift <= '0;
        end else if (tap.tck_rise && dr_sel == sbst_pkg::SEL_BOUNDARY) begin
            if (in_cap_dr) begin
                bsr_shift <= pin_sync;
            end else if (in_shf_dr) begin
                // Captured bits leave while the preload pattern arrives
                bsr_shift <= {tdi_s, bsr_shift[BSR_W-1:1]};
            end
        end
    end

    // Preload latch, written in Update-DR; only the enable cell has a preset
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            preload_out <= '0;
        end else if (in_reset) begin
            preload_out[`SBST_OE_CELL] <= `SBST_OE_RESET;
        end else if (update_dr && dr_sel == sbst_pkg::SEL_BOUNDARY) begin
            preload_out <= bsr_shift;
        end
    end

    // ----------------------------------------------------------------
    // Pin control towards the memory
    // ----------------------------------------------------------------
    // Enable cell by name; its reset preset is low, so extest floats the bus at first
    assign oe_cell = preload_out[`SBST_OE_CELL];

    // External test hands the pins to the preload latch
    always_comb begin
        next_owns  = (ir_active == `SBST_INS_EXTEST);
        next_float = 1'b0;
        if (ir_active == `SBST_INS_SAMPZ) begin
            next_float = 1'b1;
        end else if (next_owns) begin
            // Low cell floats the read bus; high lets the drivers run
            next_float = ~oe_cell;
        end
    end

    // Registered so the memory sees clean levels; one core cycle behind the instruction
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            test_owns_pins <= 1'b0;
        end else begin
            test_owns_pins <= next_owns;
        end
    end

    // Bus float on its own flop; a mode-select reset clears it with the instruction
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            q_bus_float <= 1'b0;
        end else begin
            q_bus_float <= next_float;
        end
    end

    // ----------------------------------------------------------------
    // Serial output
    // ----------------------------------------------------------------
    // Chain tail chosen by state and instruction
    always_comb begin
        next_tdo = 1'b0;
        if (in_shf_ir) begin
            next_tdo = ir_shift[0];
        end else begin
            unique case (dr_sel)
                sbst_pkg::SEL_BOUNDARY: next_tdo = bsr_shift[0];
                sbst_pkg::SEL_IDENT:    next_tdo = id_shift[0];
                sbst_pkg::SEL_BYPASS:   next_tdo = bypass_bit;
            endcase
        end
    end

    // Output moves on the falling edge so the master samples it half a period later
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tdo <= 1'b0;
        end else if (tck_fall) begin
            // Parked low outside the shift states, so no stale chain bit sits on the pin
            tdo <= is_shift(tap.state) ? next_tdo : 1'b0;
        end
    end

    // Enable shares the fall; a mode-select reset drops it at once
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tdo_oe <= 1'b0;
        end else if (tck_fall) begin
            tdo_oe <= is_shift(tap.state);
        end else if (in_reset) begin
            tdo_oe <= 1'b0;
        end
    end

endmodule // sbst_tap

// [verilog/sbst_consts.svh]
// Constants of the boundary-scan test port: widths, codes, cell positions and timing
`ifndef SBST_CONSTS_SVH
`define SBST_CONSTS_SVH

// ----------------------------------------------------------------
// Register widths
// ----------------------------------------------------------------
`define SBST_IR_W        3
`define SBST_ID_W        32
`define SBST_BSR_W       109

// ----------------------------------------------------------------
// Instruction codes
// ----------------------------------------------------------------
`define SBST_INS_EXTEST  3'h0
`define SBST_INS_IDCODE  3'h1
`define SBST_INS_SAMPZ   3'h2
`define SBST_INS_SAMPLE  3'h4
`define SBST_INS_BYPASS  3'h7
`define SBST_IR_CAPTURE  3'h1

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define SBST_OE_CELL     108
`define SBST_OE_RESET    1'h0
`define SBST_BYP_CAPTURE 1'h0
`define SBST_PULL_LEVEL  1'h1
`define SBST_ID_PRESENT  1'h1

// ----------------------------------------------------------------
// Timing: shortest legal test clock period against the core clock
// ----------------------------------------------------------------
`define SBST_CORE_PERIOD_NS 10
`define SBST_TCK_MIN_NS     50
`define SBST_TCK_MIN_CYC    ((`SBST_TCK_MIN_NS + `SBST_CORE_PERIOD_NS - 1) / `SBST_CORE_PERIOD_NS)

`endif

// [verilog/sbst_pkg.sv]
// Types shared by the boundary-scan test port modules
package sbst_pkg;

    // ----------------------------------------------------------------
    // Controller states
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE,
        ST_SEL_DR, ST_CAP_DR, ST_SHF_DR, ST_EX1_DR, ST_PAU_DR, ST_EX2_DR, ST_UPD_DR,
        ST_SEL_IR, ST_CAP_IR, ST_SHF_IR, ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
    } sbst_state_e;

    // Data register placed between serial in and serial out
    typedef enum logic [1:0] {
        SEL_BOUNDARY, SEL_IDENT, SEL_BYPASS
    } sbst_sel_e;

    typedef logic [2:0] sbst_instr_t;

endpackage : sbst_pkg

// [verilog/sbst_if.sv]
// Carrier between the test port core and its state controller
`timescale 1ns/10ps

interface sbst_if;
    logic                  tck_rise;
    logic                  tms;
    sbst_pkg::sbst_state_e state;

    modport core (output tck_rise, output tms, input state);
    modport fsm  (input tck_rise, input tms, output state);
endinterface : sbst_if

// [verilog/sbst_tap_fsm.sv]
// Sixteen-state test access controller stepped on each test clock rise
`timescale 1ns/10ps

module sbst_tap_fsm (
    input wire logic core_clk,
    input wire logic rst_n,
    sbst_if.fsm      tap
);

    sbst_pkg::sbst_state_e next_state;

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    // Power-up lands in the reset state, so the port starts quiet
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tap.state <= sbst_pkg::ST_RESET;
        end else if (tap.tck_rise) begin
            tap.state <= next_state;
        end
    end

    // ----------------------------------------------------------------
    // Transitions
    // ----------------------------------------------------------------
    // Five high mode-select samples reach reset from any state
    always_comb begin
        next_state = tap.state;
        unique case (tap.state)
            sbst_pkg::ST_RESET:  next_state = tap.tms ? sbst_pkg::ST_RESET  : sbst_pkg::ST_IDLE;
            sbst_pkg::ST_IDLE:   next_state = tap.tms ? sbst_pkg::ST_SEL_DR : sbst_pkg::ST_IDLE;
            sbst_pkg::ST_SEL_DR: next_state = tap.tms ? sbst_pkg::ST_SEL_IR : sbst_pkg::ST_CAP_DR;
            sbst_pkg::ST_CAP_DR: next_state = tap.tms ? sbst_pkg::ST_EX1_DR : sbst_pkg::ST_SHF_DR;
            sbst_pkg::ST_SHF_DR: next_state = tap.tms ? sbst_pkg::ST_EX1_DR : sbst_pkg::ST_SHF_DR;
            sbst_pkg::ST_EX1_DR: next_state = tap.tms ? sbst_pkg::ST_UPD_DR : sbst_pkg::ST_PAU_DR;
            sbst_pkg::ST_PAU_DR: next_state = tap.tms ? sbst_pkg::ST_EX2_DR : sbst_pkg::ST_PAU_DR;
            sbst_pkg::ST_EX2_DR: next_state = tap.tms ? sbst_pkg::ST_UPD_DR : sbst_pkg::ST_SHF_DR;
            sbst_pkg::ST_UPD_DR: next_state = tap.tms ? sbst_pkg::ST_SEL_DR : sbst_pkg::ST_IDLE;
            sbst_pkg::ST_SEL_IR: next_state = tap.tms ? sbst_pkg::ST_RESET  : sbst_pkg::ST_CAP_IR;
            sbst_pkg::ST_CAP_IR: next_state = tap.tms ? sbst_pkg::ST_EX1_IR : sbst_pkg::ST_SHF_IR;
            sbst_pkg::ST_SHF_IR: next_state = tap.tms ? sbst_pkg::ST_EX1_IR : sbst_pkg::ST_SHF_IR;
            sbst_pkg::ST_EX1_IR: next_state = tap.tms ? sbst_pkg::ST_UPD_IR : sbst_pkg::ST_PAU_IR;
            sbst_pkg::ST_PAU_IR: next_state = tap.tms ? sbst_pkg::ST_EX2_IR : sbst_pkg::ST_PAU_IR;
            sbst_pkg::ST_EX2_IR: next_state = tap.tms ? sbst_pkg::ST_UPD_IR : sbst_pkg::ST_SHF_IR;
            sbst_pkg::ST_UPD_IR: next_state = tap.tms ? sbst_pkg::ST_SEL_DR : sbst_pkg::ST_IDLE;
        endcase
    end

endmodule // sbst_tap_fsm

// [verif/sbst_tap_assertions.sv]
// Concurrent checks on the boundary-scan test port pins
`timescale 1ns/10ps

module sbst_tap_assertions #(
    parameter int BSR_W = 109
) (
    input wire logic             core_clk,
    input wire logic             rst_n,
    input wire logic             tck,
    input wire logic             tdo,
    input wire logic             tdo_oe,
    input wire logic [BSR_W-1:0] preload_out,
    input wire logic             test_owns_pins,
    input wire logic             q_bus_float
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    // Outputs move only well inside the low phase of the test clock
    a_tdo_on_fall: assert property ($changed(tdo) |-> !tck && !$past(tck) && !$past(tck, 2))
        else $error("Serial output moved outside the low test clock phase");
    a_oe_on_fall: assert property ($rose(tdo_oe) |-> !tck && !$past(tck, 2))
        else $error("Serial output enable rose outside the low phase");
    a_oe_hold: assert property (tck && $past(tck) |-> $stable(tdo_oe))
        else $error("Serial output enable moved while test clock high");
    a_reset_quiet: assert property ($rose(rst_n) |-> !tdo_oe && !test_owns_pins && !q_bus_float)
        else $error("Outputs not quiet after power-up reset");
    // Bus float follows the enable cell only while pins are owned
    a_float_map: assert property (test_owns_pins |-> q_bus_float == !$past(preload_out[BSR_W-1]))
        else $error("Read bus float does not follow the enable cell");
    // Bit 108 may also clear on a mode-select reset, so it is left out here
    a_preload_fall: assert property ($changed(preload_out[BSR_W-2:0]) |-> !tck && !$past(tck, 2))
        else $error("Preload latch changed outside an update fall");
    a_owns_fall: assert property ($rose(test_owns_pins) |-> !tck && !$past(tck))
        else $error("Pin ownership began outside an update fall");
    a_float_fall: assert property ($rose(q_bus_float) |-> !tck && !$past(tck))
        else $error("Read bus float began outside an update fall");

    c_owned_drive: cover property (test_owns_pins && !q_bus_float);
    c_owned_float: cover property (test_owns_pins && q_bus_float);
    c_shift: cover property ($rose(tdo_oe));
endmodule // sbst_tap_assertions

bind sbst_tap sbst_tap_assertions #(.BSR_W(BSR_W)) u_sbst_tap_assertions (
    .core_clk(core_clk), .rst_n(rst_n), .tck(tck), .tdo(tdo), .tdo_oe(tdo_oe),
    .preload_out(preload_out), .test_owns_pins(test_owns_pins), .q_bus_float(q_bus_float)
);

// [verif/sbst_master.sv]
// Scan master model: test clock, mode select and serial data in
`timescale 1ns/10ps

module sbst_master (
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo,
    input  wire logic tdo_oe
);
    // Idle lines rest high as the pull-ups leave them; clock rests low
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end

    // One 125 ns period; inputs held through the high half
    task automatic step(input logic m, input logic d, output logic q, output logic oe);
        tms = m;
        tdi = d;
        #10 tck = 1'b1;
        #62.5 tck = 1'b0;
        #52.5;
        q = tdo_oe ? tdo : ~tdo;    // Read late after the fall; an undriven pin reads inverted
        oe = tdo_oe;
    endtask

    // Idle to capture, shift n bits, update and back to Idle
    task automatic scan(input logic ir, input int n, input logic [127:0] din,
                        output logic [127:0] dout, output logic oe_all, output logic oe_end);
        logic q;
        logic oe;
        dout = '0;
        step(1'b1, 1'b1, q, oe);
        if (ir)
            step(1'b1, 1'b1, q, oe);
        step(1'b0, 1'b1, q, oe);
        step(1'b0, 1'b1, q, oe);
        dout[0] = q;
        oe_all = oe;
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q, oe);
            if (i < n - 1) begin
                dout[i+1] = q;
                oe_all = oe_all & oe;
            end
        end
        step(1'b1, 1'b1, q, oe);
        oe_end = oe;
        step(1'b0, 1'b1, q, oe);
    endtask
endmodule // sbst_master

// [verif/tb_top.sv]
// Self-checking bench of the boundary-scan test port
`timescale 1ns/10ps
`include "sbst_consts.svh"

module tb_top;
    localparam int          W   = `SBST_BSR_W;
    localparam logic [2:0]  REV = 3'h5;     // Arbitrary value
    localparam logic [16:0] DEV = 17'h1c0de; // Arbitrary value
    localparam logic [10:0] VEN = 11'h155;  // Arbitrary value
    localparam logic [31:0] ID  = {REV, DEV, VEN, `SBST_ID_PRESENT};

    logic         core_clk, rst_n, tck, tms, tdi, tdo, tdo_oe, test_owns_pins, q_bus_float;
    logic         oe_all, oe_end, tq, toe;
    logic [2:0]   ins;
    logic [W-1:0] pin_sample, preload_out, exp_pre;
    logic [127:0] dout, din, exp_out, exp_reg;
    logic         chain[$];
    int           fail_count, compares, seed;

    sbst_tap #(.BSR_W(W), .ID_REV(REV), .ID_DEVICE(DEV), .ID_VENDOR(VEN)) u_sbst_tap (
        .core_clk(core_clk), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
        .pin_sample(pin_sample), .preload_out(preload_out), .test_owns_pins(test_owns_pins),
        .q_bus_float(q_bus_float));
    sbst_master u_sbst_master (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));

    always #5 core_clk = ~core_clk;

    function automatic logic [127:0] rnd();
        return {$random(seed), $random(seed), $random(seed), $random(seed)};
    endfunction

    task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("Counts: %0d compares, %0d mismatches", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Queue model of a w-bit chain shifted w+1 times, so the length shows too
    task automatic run(input logic ir, input int w, input logic [127:0] cap, input logic [127:0] d);
        exp_out = '0;
        exp_reg = '0;
        chain = {};
        for (int i = 0; i < w; i++)
            chain.push_back(cap[i]);
        for (int i = 0; i <= w; i++) begin
            exp_out[i] = chain.pop_front();
            chain.push_back(d[i]);
        end
        for (int i = 0; i < w; i++)
            exp_reg[i] = chain[i];
        u_sbst_master.scan(ir, w + 1, d, dout, oe_all, oe_end);
        check("scan_out", dout, exp_out);
        check("oe_shift", 128'(oe_all), 128'h1);
        check("oe_after", 128'(oe_end), 128'h0);
    endtask

    task automatic check_pins(input logic [2:0] i);
        check("owns", 128'(test_owns_pins), 128'(i == `SBST_INS_EXTEST));
        check("float", 128'(q_bus_float), 128'(i == `SBST_INS_SAMPZ ||
              (i == `SBST_INS_EXTEST && !exp_pre[`SBST_OE_CELL])));
        check("preload", 128'(preload_out), 128'(exp_pre));
    endtask

    // Hang guard, reckoned at about three times the expected run
    initial begin
        #250us;
        fail_count++;
        end_sim();
    end

    initial begin
        seed = 32'h79d0;
        core_clk = 1'b0;
        rst_n = 1'b0;
        pin_sample = '0;
        exp_pre = '0;
        fail_count = 0;
        compares = 0;
        repeat (5) @(posedge core_clk);
        @(negedge core_clk) rst_n = 1'b1;
        check("oe_reset", 128'(tdo_oe), 128'h0);
        check_pins(`SBST_INS_IDCODE);
        repeat (3) @(negedge core_clk);
        #1;
        u_sbst_master.step(1'b0, 1'b1, tq, toe);
        run(1'b0, `SBST_ID_W, 128'(ID), rnd());
        $display("Test power-up done");
        // Every code, extest last; reserved codes behave as bypass
        for (int i = 1; i <= 8; i++) begin
            ins = i[2:0];
            din = rnd();
            din[3:1] = ins;
            run(1'b1, `SBST_IR_W, 128'(`SBST_IR_CAPTURE), din);
            check_pins(ins);
            @(negedge core_clk) pin_sample = W'(rnd());
            #1;
            din = rnd();
            din[W] = 1'b1;
            case (ins)
                `SBST_INS_IDCODE: run(1'b0, `SBST_ID_W, 128'(ID), din);
                `SBST_INS_EXTEST, `SBST_INS_SAMPZ, `SBST_INS_SAMPLE: begin
                    run(1'b0, W, 128'(pin_sample), din);
                    exp_pre = exp_reg[W-1:0];
                end
                default: run(1'b0, 1, 128'(`SBST_BYP_CAPTURE), din);
            endcase
            check_pins(ins);
            $display("Test instruction %0d done", ins);
        end
        repeat (5) u_sbst_master.step(1'b1, 1'b1, tq, toe);
        u_sbst_master.step(1'b0, 1'b1, tq, toe);
        exp_pre[`SBST_OE_CELL] = `SBST_OE_RESET;
        check_pins(`SBST_INS_IDCODE);
        run(1'b0, `SBST_ID_W, 128'(ID), rnd());
        din = rnd();
        din[3:1] = `SBST_INS_EXTEST;
        run(1'b1, `SBST_IR_W, 128'(`SBST_IR_CAPTURE), din);
        check_pins(`SBST_INS_EXTEST);
        $display("Test mode-select reset done");
        end_sim();
    end
endmodule // tb_top
